/* inc/lcd_drive_pkg.sv */
// Constants, register map and carrier types for the LCD drive-time,
// contrast and segment-memory block.
// Assumes a 40 MHz APB clock and a byte-addressed 12-bit APB window.
package lcd_drive_pkg;

	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned CLK_PERIOD_PS = 25000;

	// Printed offset is an index; byte address is four times it
	localparam logic [11:0] CTRL_INDEX = 12'h0E7;
	localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX[9:0], 2'b00};
	localparam logic [11:0] MODE_ADDR = 12'h3A0;
	localparam logic [11:0] STAT_ADDR = 12'h3A4;
	localparam logic [11:0] SEG_BASE = 12'h400;
	localparam int unsigned SEG_BYTES = 20;
	localparam int unsigned SEG_STRIDE = 5;
	localparam int unsigned SEG_COUNT = 25;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [9:0] MODE_RESET = 10'h000;
	localparam logic [7:0] SEG_RESET = 8'h00;

	// Nominal drive times in microseconds, codes 0 to 6
	localparam int unsigned DRIVE_US [7] = '{300, 70, 150, 450, 575, 850, 1150};
	localparam logic [2:0] DRIVE_HALF_CODE = 3'h7;

	localparam int unsigned VLCD_BASE_MV = 2600;
	localparam int unsigned VLCD_STEP_MV = 50;

	localparam logic [2:0] K_FULL = 3'h7;
	localparam logic [2:0] K_THIRD = 3'h5;

	// Prescaler tap ratio minus one, per tap select code
	localparam logic [11:0] PS_N_M1 [8] = '{12'h00F, 12'h03F, 12'h07F, 12'h0FF,
		12'h1FF, 12'h3FF, 12'h7FF, 12'hFFF};

	typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} duty_t;

	typedef struct packed {
		logic [2:0] drive_time_select;
		logic max_drive_enable;
		logic [3:0] contrast_level;
	} ctrl_t;

	typedef struct packed {
		logic [2:0] frame_clock_divider;
		logic [2:0] prescaler_tap_select;
		logic blank;
		logic half_bias_select;
		duty_t duty;
	} mode_t;

	typedef struct packed {
		logic drive_on;
		logic [1:0] common_line;
		logic polarity;
		logic [24:0] segment_line;
		logic [11:0] max_drive_voltage_mv;
		logic half_bias;
		logic static_bias;
		logic [3:0] contrast_applied;
	} drive_out_t;

endpackage

/* rtl/lcd_drive_contrast_segment_memory.sv */
// LCD drive-time, contrast and segment-memory block with APB registers.
// Assumes lcd_clock_tick pulses once per LCD source clock, synchronous to pclk.
//
// Function
// - Decode drive time code to on-times
// - On-time never exceeds half prescaled period unless max drive is set
// - Static bias or blank forces half period
// - Max drive bit keeps drivers on always
// - Contrast code maps linearly 2.60-3.35 V
// - New contrast applies at next frame start
// - Set memory bit energizes its segment
// - Unused memory bits are plain storage
// - Byte 5n+k holds common n segments
// - Frame rate is clock over K*N*D
// - Static bias in static duty, else half bias if selected, else third
`timescale 1ns/1ps
`default_nettype none

module lcd_drive_contrast_segment_memory #(
	parameter int unsigned DRIVE_CYC [7] = '{
		lcd_drive_pkg::DRIVE_US[0] * lcd_drive_pkg::CLK_MHZ,
		lcd_drive_pkg::DRIVE_US[1] * lcd_drive_pkg::CLK_MHZ,
		lcd_drive_pkg::DRIVE_US[2] * lcd_drive_pkg::CLK_MHZ,
		lcd_drive_pkg::DRIVE_US[3] * lcd_drive_pkg::CLK_MHZ,
		lcd_drive_pkg::DRIVE_US[4] * lcd_drive_pkg::CLK_MHZ,
		lcd_drive_pkg::DRIVE_US[5] * lcd_drive_pkg::CLK_MHZ,
		lcd_drive_pkg::DRIVE_US[6] * lcd_drive_pkg::CLK_MHZ}
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lcd_clock_tick,
	output logic frame_start,
	output lcd_drive_pkg::drive_out_t drv
);
	import lcd_drive_pkg::*;

	// Register file
	ctrl_t ctrl_q, ctrl_d;
	mode_t mode_q, mode_d;
	logic [7:0] seg_q [SEG_BYTES];
	logic hit_ctrl, hit_mode, hit_stat, hit_seg;
	logic [4:0] seg_idx;
	logic [31:0] rd_mux;
	logic [31:0] stat_word;
	logic rd_err;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic setup_ph, wr_en;
	logic [11:0] seg_off;

	// Timing chain
	logic [11:0] ps_cnt_q, ps_cnt_d;
	logic [2:0] div_cnt_q, div_cnt_d;
	logic [2:0] phase_q, phase_d;
	logic [23:0] per_cnt_q, per_cnt_d;
	logic [23:0] period_q, period_d;
	logic [23:0] drv_cnt_q, drv_cnt_d;
	logic [3:0] cc_app_q, cc_app_d;
	logic frame_q, frame_d;
	logic ps_wrap, ps_tick, frame_wrap;
	logic [2:0] k_m1;
	logic [23:0] half_cyc, nominal, on_limit;
	logic [1:0] com;
	logic [23:0] drive_tab [8];
	logic [24:0] seg_row [4];
	logic static_sel, half_sel;

	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign seg_off = paddr - SEG_BASE;
	assign seg_idx = seg_off[6:2];

	// Address decode shared by the write and the read path
	always_comb begin
		hit_ctrl = 1'b0;
		hit_mode = 1'b0;
		hit_stat = 1'b0;
		hit_seg = 1'b0;
		// Misaligned or out-of-range segment offsets fall through to error
		if (paddr == CTRL_ADDR) begin
			hit_ctrl = 1'b1;
		end else if (paddr == MODE_ADDR) begin
			hit_mode = 1'b1;
		end else if (paddr == STAT_ADDR) begin
			hit_stat = 1'b1;
		end else if (paddr >= SEG_BASE && seg_off < 12'(SEG_BYTES * 4)
				&& paddr[1:0] == 2'b00) begin
			hit_seg = 1'b1;
		end
	end

	// Control and mode registers
	always_comb begin
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		if (wr_en && hit_ctrl) begin
			ctrl_d = pwdata[7:0];
		end
		if (wr_en && hit_mode) begin
			mode_d = pwdata[9:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
			mode_q <= MODE_RESET;
		end else if (clk_en) begin
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
		end
	end

	// One storage byte per display memory location
	// Bytes 5n+4 drive no segment and serve as plain storage
	for (genvar g = 0; g < SEG_BYTES; g++) begin : g_seg
		logic [7:0] byte_d;
		always_comb begin
			byte_d = seg_q[g];
			if (wr_en && hit_seg && seg_idx == 5'(g)) begin
				byte_d = pwdata[7:0];
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				seg_q[g] <= SEG_RESET;
			end else if (clk_en) begin
				seg_q[g] <= byte_d;
			end
		end
	end

	// Status word: applied contrast, common line, driver state and phase
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[3:0] = cc_app_q;
		stat_word[5:4] = com;
		stat_word[6] = drv.drive_on;
		stat_word[10:8] = phase_q;
	end

	// Read word for the addressed register
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (hit_ctrl) begin
			rd_mux[7:0] = ctrl_q;
		end else if (hit_mode) begin
			rd_mux[9:0] = mode_q;
		end else if (hit_stat) begin
			rd_mux = stat_word;
		end else if (hit_seg) begin
			rd_mux[7:0] = seg_q[seg_idx];
		end else begin
			rd_err = 1'b1;
		end
	end

	// Read data and error flag are captured in the setup cycle
	// Writes to the status or unmapped addresses are dropped
	always_comb begin
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup_ph) begin
			rdata_d = rd_mux;
			err_d = rd_err;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (clk_en) begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Zero wait states; slave answers in the first access cycle
	assign pready = 1'b1;
	assign prdata = rdata_q;
	assign pslverr = err_q & psel & penable;

	// Prescaler N, divider D and K phases per frame
	always_comb begin
		case (mode_q.duty)
			DUTY_THIRD: k_m1 = K_THIRD;
			default: k_m1 = K_FULL;
		endcase
		ps_wrap = lcd_clock_tick && ps_cnt_q >= PS_N_M1[mode_q.prescaler_tap_select];
		ps_tick = ps_wrap && div_cnt_q >= mode_q.frame_clock_divider;
		frame_wrap = ps_tick && phase_q >= k_m1;
	end

	// Prescaler tap counter, N source ticks per wrap
	always_comb begin
		ps_cnt_d = ps_cnt_q;
		if (lcd_clock_tick) begin
			ps_cnt_d = ps_wrap ? 12'h000 : ps_cnt_q + 12'h001;
		end
	end

	// Clock divider, D prescaler wraps per prescaled tick
	always_comb begin
		div_cnt_d = div_cnt_q;
		if (ps_wrap) begin
			div_cnt_d = ps_tick ? 3'h0 : div_cnt_q + 3'h1;
		end
	end

	// Frame phase, K prescaled ticks per frame
	always_comb begin
		phase_d = phase_q;
		if (ps_tick) begin
			phase_d = frame_wrap ? 3'h0 : phase_q + 3'h1;
		end
		frame_d = frame_wrap;
	end

	// Prescaled period measured in pclk cycles, for the half-period limit
	always_comb begin
		per_cnt_d = per_cnt_q;
		period_d = period_q;
		if (ps_tick) begin
			per_cnt_d = 24'h000000;
			period_d = (per_cnt_q == 24'hFFFFFF) ? per_cnt_q : per_cnt_q + 24'h000001;
		end else if (per_cnt_q != 24'hFFFFFF) begin
			per_cnt_d = per_cnt_q + 24'h000001;
		end
		half_cyc = {1'b0, period_q[23:1]};
	end

	// Cycle counts per drive time code; the top code follows the measured half period
	for (genvar t = 0; t < 7; t++) begin : g_tab
		assign drive_tab[t] = 24'(DRIVE_CYC[t]);
	end
	assign drive_tab[DRIVE_HALF_CODE] = half_cyc;

	// Driver on-time per transition
	always_comb begin
		nominal = drive_tab[ctrl_q.drive_time_select];
		// Static bias and blanking ignore the selected code
		// Longer nominal times are clipped to half a period
		if (static_sel || mode_q.blank) begin
			on_limit = half_cyc;
		end else if (nominal > half_cyc) begin
			on_limit = half_cyc;
		end else begin
			on_limit = nominal;
		end
		drv_cnt_d = drv_cnt_q;
		if (ps_tick) begin
			drv_cnt_d = on_limit;
		end else if (drv_cnt_q != 24'h000000) begin
			drv_cnt_d = drv_cnt_q - 24'h000001;
		end
	end

	// Contrast code waits for the frame boundary
	always_comb begin
		cc_app_d = frame_wrap ? ctrl_q.contrast_level : cc_app_q;
	end

	// Prescaler state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_cnt_q <= 12'h000;
		end else if (clk_en) begin
			ps_cnt_q <= ps_cnt_d;
		end
	end

	// Divider state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 3'h0;
		end else if (clk_en) begin
			div_cnt_q <= div_cnt_d;
		end
	end

	// Phase state and frame pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 3'h0;
			frame_q <= 1'b0;
		end else if (clk_en) begin
			phase_q <= phase_d;
			frame_q <= frame_d;
		end
	end

	// Period measurement state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt_q <= 24'h000000;
			period_q <= 24'h000000;
		end else if (clk_en) begin
			per_cnt_q <= per_cnt_d;
			period_q <= period_d;
		end
	end

	// On-time counter state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_cnt_q <= 24'h000000;
		end else if (clk_en) begin
			drv_cnt_q <= drv_cnt_d;
		end
	end

	// Applied contrast state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc_app_q <= 4'h0;
		end else if (clk_en) begin
			cc_app_q <= cc_app_d;
		end
	end

	assign frame_start = frame_q;

	// Common line walks through the frame according to duty
	always_comb begin
		case (mode_q.duty)
			DUTY_STATIC: com = 2'h0;
			DUTY_HALF: com = {1'b0, phase_q[2]};
			default: com = phase_q[2:1];
		endcase
	end

	// Segment row of each common line in the display memory
	for (genvar c = 0; c < 4; c++) begin : g_row
		assign seg_row[c] = {seg_q[SEG_STRIDE * c + 3][0], seg_q[SEG_STRIDE * c + 2],
			seg_q[SEG_STRIDE * c + 1], seg_q[SEG_STRIDE * c]};
	end

	// Bias selection; static duty has no divided bias levels
	assign static_sel = (mode_q.duty == DUTY_STATIC);
	assign half_sel = ~static_sel & mode_q.half_bias_select;

	// Drive outputs, all decoded from flip-flops with no path from the inputs
	always_comb begin
		// Max drive overrides the on-time counter
		drv.drive_on = ctrl_q.max_drive_enable | (drv_cnt_q != 24'h000000);
		drv.common_line = com;
		drv.polarity = phase_q[0];
		drv.segment_line = 25'h0000000;
		if (!mode_q.blank) begin
			drv.segment_line = seg_row[com];
		end
		drv.max_drive_voltage_mv = 12'(VLCD_BASE_MV + VLCD_STEP_MV * cc_app_q);
		drv.static_bias = static_sel;
		drv.half_bias = half_sel;
		drv.contrast_applied = cc_app_q;
	end

endmodule

`default_nettype wire

/* tb/lcd_drive_sva.sv */
// Concurrent checks on the ports of the LCD drive block, bound to it below.
// Assumes the package register map and a single pclk domain.
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_sva
	import lcd_drive_pkg::*;
#(
	parameter int unsigned DRIVE_CYC [7] = '{30, 7, 15, 45, 57, 85, 115}
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lcd_clock_tick,
	input wire logic frame_start,
	input wire lcd_drive_pkg::drive_out_t drv
);
	logic [7:0] ctl_q;
	logic blank_q;
	logic hb_q;
	logic [1:0] duty_q;
	logic wr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = psel && penable && pwrite && clk_en;
	// Shadow of the control byte and the blank bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 8'h00;
			blank_q <= 1'b0;
			hb_q <= 1'b0;
			duty_q <= 2'h0;
		end else if (wr && paddr == CTRL_ADDR) begin
			ctl_q <= pwdata[7:0];
		end else if (wr && paddr == MODE_ADDR) begin
			blank_q <= pwdata[3];
			hb_q <= pwdata[2];
			duty_q <= pwdata[1:0];
		end
	end
	property p_maxdrv; ctl_q[4] |-> drv.drive_on; endproperty
	a_maxdrv: assert property (p_maxdrv) else $error("driver off in max drive");
	property p_volt; drv.max_drive_voltage_mv == 12'(VLCD_BASE_MV + VLCD_STEP_MV * drv.contrast_applied); endproperty
	a_volt: assert property (p_volt) else $error("voltage not linear in contrast");
	property p_hold; !frame_start |-> $stable(drv.contrast_applied); endproperty
	a_hold: assert property (p_hold) else $error("contrast changed mid frame");
	property p_blank; blank_q |-> drv.segment_line == 25'h0; endproperty
	a_blank: assert property (p_blank) else $error("segments lit while blank");
	property p_bias; drv.static_bias |-> !drv.half_bias; endproperty
	a_bias: assert property (p_bias) else $error("half bias in static");
	property p_hb; drv.half_bias == (duty_q != 2'h0 && hb_q); endproperty
	a_hb: assert property (p_hb) else $error("bias select wrong");
	property p_static; drv.static_bias == (duty_q == 2'h0); endproperty
	a_static: assert property (p_static) else $error("static bias flag wrong");
	property p_com; drv.static_bias |-> drv.common_line == 2'h0; endproperty
	a_com: assert property (p_com) else $error("common line moved in static duty");
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("access phase not ready");
	property p_gap; frame_start |=> !frame_start [*8]; endproperty
	a_gap: assert property (p_gap) else $error("frames too close");
	property p_rd; psel && penable && !pwrite && paddr == CTRL_ADDR |-> prdata == {24'h0, ctl_q}; endproperty
	a_rd: assert property (p_rd) else $error("control readback wrong");
	property p_err; pslverr |-> psel && penable && paddr != CTRL_ADDR; endproperty
	a_err: assert property (p_err) else $error("error flag misplaced");
	c_frame: cover property (frame_start);
	c_max: cover property (ctl_q[4] && drv.drive_on);
	c_blank: cover property (blank_q && frame_start);
	c_half: cover property (drv.half_bias && frame_start);
endmodule
bind lcd_drive_contrast_segment_memory lcd_drive_sva #(.DRIVE_CYC(DRIVE_CYC)) u_lcd_drive_sva (.pclk(pclk),
	.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lcd_clock_tick(lcd_clock_tick),
	.frame_start(frame_start), .drv(drv));
`default_nettype wire

/* tb/lcd_glass_model.sv */
// Segment glass: remembers what each common line last showed.
// Assumes drv from the LCD drive block.
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_model
	import lcd_drive_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire lcd_drive_pkg::drive_out_t drv,
	output logic [99:0] lit
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lit <= '0;
		end else if (drv.drive_on) begin
			lit[drv.common_line * 25 +: 25] <= drv.segment_line;
		end
	end
endmodule
`default_nettype wire

/* tb/lcd_drive_contrast_segment_memory_test.sv */
// Self-checking bench for the LCD drive block.
// Assumes small drive counts and an LCD tick every second pclk.
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_contrast_segment_memory_test;
	import lcd_drive_pkg::*;
	localparam int unsigned DC [7] = '{30, 7, 15, 45, 57, 85, 115};
	logic pclk, presetn, psel, penable, pwrite, tick, pready, pslverr, frame_start;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	drive_out_t drv;
	logic [99:0] lit;
	logic [32:0] exp_q[$];
	logic [7:0] mem[20];
	int fail_count, n_tests, m, fl;
	lcd_drive_contrast_segment_memory #(.DRIVE_CYC(DC)) u_lcd_drive_contrast_segment_memory (.pclk(pclk),
		.presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lcd_clock_tick(tick),
		.frame_start(frame_start), .drv(drv));
	lcd_glass_model u_lcd_glass_model (.pclk(pclk), .presetn(presetn), .drv(drv), .lit(lit));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) tick <= ~tick;
	task automatic stop_test;
		if (fail_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input bit t);
		if (t) begin
			fail_count++;
			$display("BAD %0t timeout", $time);
			stop_test();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		if (!w) exp_q.push_back(e);
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		tmo(i >= 50);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_frame;
		int i;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (frame_start !== 1'b1 && i < 5000);
		tmo(i >= 5000);
		fl = i;
	endtask
	task automatic run_len(output int n);
		int i;
		i = 0;
		while (drv.drive_on !== 1'b0 && i < 500) begin
			@(posedge pclk);
			i++;
		end
		while (drv.drive_on !== 1'b1 && i < 1000) begin
			@(posedge pclk);
			i++;
		end
		tmo(i >= 1000);
		n = 0;
		while (drv.drive_on === 1'b1 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// Read results are compared where the access phase has settled
	always @(negedge pclk) begin
		if (psel && penable && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
	end
	initial begin
		{psel, penable, pwrite, tick, presetn, paddr, pwdata} = '0;
		void'($urandom(64964));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, CTRL_ADDR, 0, 33'h0);
		apb(0, 12'h010, 0, {1'b1, 32'h0});
		for (int i = 0; i < 20; i++) begin
			mem[i] = 8'($urandom);
			apb(0, SEG_BASE + 12'(4 * i), 0, 33'h0);
			apb(1, SEG_BASE + 12'(4 * i), {24'h0, mem[i]}, 33'h0);
			apb(0, SEG_BASE + 12'(4 * i), 0, {25'h0, mem[i]});
		end
		apb(1, MODE_ADDR, 32'h13, 33'h0);
		wait_frame();
		wait_frame();
		for (int n = 0; n < 4; n++) begin
			chk(33'(lit[n * 25 +: 25]), 33'({mem[5 * n + 3][0], mem[5 * n + 2], mem[5 * n + 1], mem[5 * n]}));
		end
		wait_frame();
		chk(33'(fl), 33'd1024);
		apb(1, MODE_ADDR, 32'h12, 33'h0);
		wait_frame();
		wait_frame();
		chk(33'(fl), 33'd768);
		apb(1, MODE_ADDR, 32'h13, 33'h0);
		for (int c = 0; c < 16; c++) begin
			wait_frame();
			apb(1, CTRL_ADDR, 32'(c), 33'h0);
			chk(33'(drv.contrast_applied), 33'(c > 0 ? c - 1 : 0));
			wait_frame();
			chk(33'(drv.max_drive_voltage_mv), 33'(VLCD_BASE_MV + VLCD_STEP_MV * c));
		end
		for (int k = 0; k < 8; k++) begin
			apb(1, CTRL_ADDR, 32'(k << 5), 33'h0);
			run_len(m);
			run_len(m);
			chk(33'(m), 33'(k == 7 ? 64 : (DC[k % 7] < 64 ? DC[k % 7] : 64)));
		end
		apb(1, CTRL_ADDR, 32'h20, 33'h0);
		for (int j = 0; j < 2; j++) begin
			apb(1, MODE_ADDR, j ? 32'h1F : 32'h10, 33'h0);
			run_len(m);
			run_len(m);
			chk(33'(m), 33'd64);
		end
		apb(1, CTRL_ADDR, 32'h10, 33'h0);
		repeat (300) @(posedge pclk);
		chk(33'(drv.drive_on), 33'h1);
		stop_test();
	end
endmodule
`default_nettype wire
